// >>> hw/see_pkg.sv
// Shared constants and types for the serial EEPROM command block
package see_pkg;
  localparam int ADDR_W = 11;
  localparam int MEM_WORDS = 2 ** ADDR_W;
  localparam int PAGE_BYTES_DEF = 32;
  // Opcodes, shifted most significant bit first
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_ARRAY_WR = 8'h02;
  localparam logic [7:0] OP_ARRAY_RD = 8'h03;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  // Block-protect settings and region bases
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 11'h600;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 11'h400;
  // Status byte bit positions
  localparam int SR_SWD = 7;
  localparam int SR_BPHI = 3;
  localparam int SR_BPLO = 2;
  localparam int SR_WEL = 1;
  localparam int SR_WIP = 0;
  // Frame byte counts
  localparam logic [2:0] CNT_CMD_LEN = 3'h1;
  localparam logic [2:0] CNT_STAT_LEN = 3'h2;
  localparam logic [2:0] CNT_ADDR_DONE = 3'h3;
  localparam logic [2:0] CNT_WR_MIN = 3'h4;
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam logic [7:0] MEM_RESET = 8'hFF;
  localparam logic [7:0] MEM_ERASED = 8'h00;
  // Write cycle timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_CYCLE_TIME_NS = 5000000;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TW_CYCLES_DEF = TMR_W'(
    (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ERASE = 2'b01,
    PH_PROG = 2'b11
  } see_phase_t;
endpackage : see_pkg

// >>> hw/see_link_if.sv
// Carrier between the serial-clock front end and the core
`timescale 1ns/1ps
interface see_link_if #(
  parameter int PAGE_BYTES = 32
) ();
  logic [7:0] opcode;
  logic [10:0] addr;
  logic [2:0] byteCnt;
  logic byteDone;
  logic frameTog;
  logic [7:0] statData;
  logic [PAGE_BYTES-1:0][7:0] pageData;
  logic [PAGE_BYTES-1:0] pageMask;
  logic [10:0] rdAddr;
  logic [7:0] rdData;
  logic write_in_progress;
  modport link(output opcode, addr, byteCnt, byteDone, frameTog, statData,
    pageData, pageMask, rdAddr, input rdData, write_in_progress);
  modport core(input opcode, addr, byteCnt, byteDone, frameTog, statData,
    pageData, pageMask, rdAddr, output rdData, write_in_progress);
endinterface : see_link_if

// >>> hw/see_link.sv
// Serial-clock front end: shifts frames in, read data out
`timescale 1ns/1ps
module see_link import see_pkg::*; #(
  parameter int PAGE_BYTES = PAGE_BYTES_DEF
) (
  input wire logic spiClk,
  input wire logic rstn,
  input wire logic chipEnableN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  see_link_if.link lk
);
  localparam int SLOT_W = $clog2(PAGE_BYTES);
  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] ptr;
    logic [SLOT_W-1:0] slot;
    logic [2:0] byteCnt;
    logic byteDone;
    logic frameTog;
    logic readOk;
    logic wipMeta;
    logic wipSync;
    logic [7:0] statData;
    logic [PAGE_BYTES-1:0][7:0] pageData;
    logic [PAGE_BYTES-1:0] pageMask;
  } see_link_t;
  see_link_t s_r, s_nxt;
  logic [2:0] bitPos_r;
  logic inFrame_r;
  logic serialOut_r;
  logic [7:0] byteNow;
  logic [2:0] cnt;

  // Deselect clears position
  // Kept apart so a mid-byte deselect ends the frame with no clock edge
  always_ff @(posedge spiClk or negedge rstn or posedge chipEnableN) begin
    if (!rstn || chipEnableN) begin
      bitPos_r <= 3'h0;
      inFrame_r <= 1'b0;
    end else begin
      bitPos_r <= bitPos_r + 3'h1;
      inFrame_r <= 1'b1;
    end
  end

  always_comb begin
    s_nxt = s_r;
    cnt = inFrame_r ? s_r.byteCnt : 3'h0;
    byteNow = {s_r.sh[6:0], serialIn};
    s_nxt.wipMeta = lk.write_in_progress;
    s_nxt.wipSync = s_r.wipMeta;
    s_nxt.sh = byteNow;
    s_nxt.byteDone = (bitPos_r == 3'h7);
    s_nxt.byteCnt = cnt;
    if (!inFrame_r) begin
      s_nxt.frameTog = ~s_r.frameTog;
      s_nxt.pageMask = '0;
      s_nxt.readOk = 1'b0;
    end
    if (bitPos_r == 3'h7) begin
      if (cnt != CNT_MAX) begin
        s_nxt.byteCnt = cnt + 3'h1;
      end
      if (cnt == 3'h0) begin
        s_nxt.opcode = byteNow;
        s_nxt.readOk = (byteNow == OP_ARRAY_RD) && !s_r.wipSync;
      end else if (cnt == CNT_CMD_LEN) begin
        s_nxt.addr = {byteNow[2:0], s_r.addr[7:0]};
        s_nxt.statData = byteNow;
      end else if (cnt == CNT_STAT_LEN) begin
        s_nxt.addr = {s_r.addr[ADDR_W-1:8], byteNow};
        s_nxt.ptr = {s_r.addr[ADDR_W-1:8], byteNow};
        s_nxt.slot = byteNow[SLOT_W-1:0];
      end else begin
        s_nxt.pageData[s_r.slot] = byteNow;
        s_nxt.pageMask[s_r.slot] = 1'b1;
        s_nxt.slot = s_r.slot + SLOT_W'(1);
        s_nxt.ptr = s_r.ptr + ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge spiClk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Falling-edge launch gives the host a full half period of setup
  always_ff @(negedge spiClk or negedge rstn) begin
    if (!rstn) begin
      serialOut_r <= 1'b0;
    end else if (s_r.readOk && s_r.byteCnt >= CNT_ADDR_DONE) begin
      serialOut_r <= lk.rdData[3'h7 - bitPos_r];
    end else begin
      serialOut_r <= 1'b0;
    end
  end

  assign serialOut = serialOut_r;
  // Frame flag masks a stale read grant before the next frame's first edge
  assign serialOutOe = s_r.readOk & inFrame_r & ~chipEnableN;
  assign lk.opcode = s_r.opcode;
  assign lk.addr = s_r.addr;
  assign lk.byteCnt = s_r.byteCnt;
  assign lk.byteDone = s_r.byteDone;
  assign lk.frameTog = s_r.frameTog;
  assign lk.statData = s_r.statData;
  assign lk.pageData = s_r.pageData;
  assign lk.pageMask = s_r.pageMask;
  assign lk.rdAddr = s_r.ptr;
endmodule : see_link

// >>> hw/see_core.sv
// Core of the serial EEPROM: status, protection, write cycle, array
`timescale 1ns/1ps
// Summary of operation
// - Status write needs write-enable latch set
// - Status write: opcode, one byte, deselect
// - Deselect at boundary starts timed cycle
// - Busy flag one during cycle, then zero
// - Cycle end clears write-enable latch
// - Only protect bits change, after cycle
// - Bits six to four read zero
// - Disable bit zero: pin level ignored
// - Disable bit one, pin low: rejected
// - Hardware protection until pin goes high
// - Protected region refuses array writes
// - Read: opcode, address, bytes stream out
// - Read address wraps to zero
// - Deselect ends read at once
// - No read while write cycle runs
// - Array write: opcode, address, data bytes
// - Page address wraps inside page
// - Discard write on latch, busy, boundary
// - Cycle erases to zero, then programs
// - Opcodes one, two, three, MSB first
// - Protect settings select upper regions
// - Status byte layout fixed
// - Only eleven address bits significant
module see_core import see_pkg::*; #(
  parameter int PAGE_BYTES = PAGE_BYTES_DEF,
  parameter logic [TMR_W-1:0] TW_CYCLES = TW_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic spiClk,
  input wire logic chipEnableN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  input wire logic protectPinN,
  output logic [7:0] statusByte,
  output logic writeInProgress,
  output logic writeEnableLatch,
  output logic statusWriteDisable,
  output logic blockProtectHi,
  output logic blockProtectLo,
  output logic hardwareProtectedMode,
  output logic softwareProtectedMode
);
  localparam logic [ADDR_W-1:0] PAGE_MASK = ADDR_W'(PAGE_BYTES - 1);
  localparam logic [TMR_W-1:0] HALF_CYCLES = TW_CYCLES >> 1;

  typedef struct packed {
    logic [MEM_WORDS-1:0][7:0] mem;
    logic [PAGE_BYTES-1:0][7:0] pendData;
    logic [PAGE_BYTES-1:0] pendMask;
    logic [ADDR_W-1:0] pendBase;
    logic pendStat;
    logic [7:0] pendSr;
    logic [TMR_W-1:0] timer;
    see_phase_t phase;
    logic swd;
    logic [1:0] bp;
    logic write_enable_latch;
    logic ceMeta;
    logic ceSync;
    logic ceDly;
    logic wpMeta;
    logic wpSync;
    logic togSeen;
  } see_core_t;

  localparam see_core_t ST_RST = '{
    mem: {MEM_WORDS{MEM_RESET}},
    phase: PH_IDLE,
    ceMeta: 1'b1,
    ceSync: 1'b1,
    ceDly: 1'b1,
    wpMeta: 1'b1,
    wpSync: 1'b1,
    default: '0
  };

  see_core_t s_r, s_nxt;
  logic ceRise;
  logic fresh;
  logic frameOk;
  logic stWrReq;
  logic arWrReq;
  logic stAcc;
  logic arAcc;
  logic idle;
  logic hardware_protected_mode;
  logic prot;
  logic [ADDR_W-1:0] pgBase;
  logic [TMR_W-1:0] wipCnt_r;

  see_link_if #(.PAGE_BYTES(PAGE_BYTES)) lk ();

  see_link #(.PAGE_BYTES(PAGE_BYTES)) u_link (
    .spiClk(spiClk),
    .rstn(rstn),
    .chipEnableN(chipEnableN),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .serialOutOe(serialOutOe),
    .lk(lk.link)
  );

  function automatic logic isProt(input logic [1:0] bp,
                                  input logic [ADDR_W-1:0] a);
    unique case (bp)
      BP_NONE: isProt = 1'b0;
      BP_QTR: isProt = (a >= PROT_QTR_BASE);
      BP_HALF: isProt = (a >= PROT_HALF_BASE);
      BP_ALL: isProt = 1'b1;
    endcase
  endfunction : isProt

  // Link fields are quiet here: the serial clock stops once deselected
  assign ceRise = s_r.ceSync & ~s_r.ceDly;
  // Toggle guards against a deselect pulse with no clock edges
  assign fresh = ceRise && (lk.frameTog != s_r.togSeen);
  assign frameOk = fresh && lk.byteDone;
  assign stWrReq = frameOk && (lk.opcode == OP_STATUS_WR)
                   && (lk.byteCnt == CNT_STAT_LEN);
  assign arWrReq = frameOk && (lk.opcode == OP_ARRAY_WR)
                   && (lk.byteCnt >= CNT_WR_MIN);
  assign pgBase = lk.addr & ~PAGE_MASK;
  assign idle = (s_r.phase == PH_IDLE);
  assign hardware_protected_mode = s_r.swd & ~s_r.wpSync;
  assign prot = isProt(s_r.bp, pgBase);
  assign stAcc = stWrReq && s_r.write_enable_latch && idle && !hardware_protected_mode;
  assign arAcc = arWrReq && s_r.write_enable_latch && idle && !prot;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ceMeta = chipEnableN;
    s_nxt.ceSync = s_r.ceMeta;
    s_nxt.ceDly = s_r.ceSync;
    s_nxt.wpMeta = protectPinN;
    s_nxt.wpSync = s_r.wpMeta;
    if (ceRise) begin
      s_nxt.togSeen = lk.frameTog;
    end
    unique case (s_r.phase)
      PH_IDLE: begin
        s_nxt.timer = '0;
        if (stAcc || arAcc) begin
          s_nxt.phase = PH_ERASE;
          s_nxt.pendStat = stAcc;
          s_nxt.pendSr = lk.statData;
          s_nxt.pendBase = pgBase;
          s_nxt.pendData = lk.pageData;
          s_nxt.pendMask = stAcc ? '0 : lk.pageMask;
        end
      end
      PH_ERASE: begin
        s_nxt.timer = s_r.timer + TMR_W'(1);
        if (s_r.timer == HALF_CYCLES - TMR_W'(1)) begin
          s_nxt.phase = PH_PROG;
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (s_r.pendMask[i]) begin
              s_nxt.mem[s_r.pendBase | ADDR_W'(i)] = MEM_ERASED;
            end
          end
        end
      end
      PH_PROG: begin
        s_nxt.timer = s_r.timer + TMR_W'(1);
        if (s_r.timer == TW_CYCLES - TMR_W'(1)) begin
          s_nxt.phase = PH_IDLE;
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (s_r.pendMask[i]) begin
              s_nxt.mem[s_r.pendBase | ADDR_W'(i)] = s_r.pendData[i];
            end
          end
          if (s_r.pendStat) begin
            s_nxt.swd = s_r.pendSr[SR_SWD];
            s_nxt.bp = {s_r.pendSr[SR_BPHI], s_r.pendSr[SR_BPLO]};
          end
          s_nxt.write_enable_latch = 1'b0;
        end
      end
      default: begin
        s_nxt.phase = PH_IDLE;
      end
    endcase
    // Enable after the end-of-cycle clear so a set in the same cycle wins
    if (frameOk && lk.byteCnt == CNT_CMD_LEN) begin
      if (lk.opcode == OP_WR_ENABLE) begin
        s_nxt.write_enable_latch = 1'b1;
      end else if (lk.opcode == OP_WR_DISABLE) begin
        s_nxt.write_enable_latch = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array is steady whenever reads are allowed, so no crossing needed
  assign lk.rdData = s_r.mem[lk.rdAddr];
  assign lk.write_in_progress = (s_r.phase != PH_IDLE);
  assign writeInProgress = lk.write_in_progress;
  assign writeEnableLatch = s_r.write_enable_latch;
  assign statusWriteDisable = s_r.swd;
  assign blockProtectHi = s_r.bp[1];
  assign blockProtectLo = s_r.bp[0];
  assign hardwareProtectedMode = hardware_protected_mode;
  assign softwareProtectedMode = ~hardware_protected_mode;
  assign statusByte = {s_r.swd, 3'h0, s_r.bp, s_r.write_enable_latch, lk.write_in_progress};

  // Cycle length helper for the checks below
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wipCnt_r <= '0;
    end else if (lk.write_in_progress) begin
      wipCnt_r <= wipCnt_r + TMR_W'(1);
    end else begin
      wipCnt_r <= '0;
    end
  end

  property p_wip_hold;
    @(posedge core_clk) disable iff (!rstn)
    $rose(writeInProgress) |-> writeInProgress [*8];
  endproperty
  a_wip_hold: assert property (p_wip_hold)
    else $error("write cycle shorter than eight cycles");

  property p_wip_len;
    @(posedge core_clk) disable iff (!rstn)
    $fell(writeInProgress) |->
      $past(wipCnt_r) == TW_CYCLES - TMR_W'(1);
  endproperty
  a_wip_len: assert property (p_wip_len)
    else $error("write cycle length differs from write cycle time");

  property p_wel_clear;
    @(posedge core_clk) disable iff (!rstn)
    $fell(writeInProgress) |-> !writeEnableLatch
      || ($past(frameOk) && $past(lk.opcode) == OP_WR_ENABLE);
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch still set after write cycle");

  property p_sr_stable;
    @(posedge core_clk) disable iff (!rstn)
    !$stable({statusWriteDisable, blockProtectHi, blockProtectLo})
      |-> $fell(writeInProgress) && $past(s_r.pendStat);
  endproperty
  a_sr_stable: assert property (p_sr_stable)
    else $error("protect bits changed outside a status cycle end");

  property p_sr_zero;
    @(posedge core_clk) disable iff (!rstn)
    statusByte[6:4] == 3'h0 && statusByte[SR_WIP] == writeInProgress;
  endproperty
  a_sr_zero: assert property (p_sr_zero)
    else $error("status byte layout wrong");

  property p_sw_accept;
    @(posedge core_clk) disable iff (!rstn)
    (stWrReq && writeEnableLatch && !statusWriteDisable && idle)
      |=> writeInProgress;
  endproperty
  a_sw_accept: assert property (p_sw_accept)
    else $error("status write refused with disable bit clear");

  property p_hw_reject;
    @(posedge core_clk) disable iff (!rstn)
    (stWrReq && hardware_protected_mode && idle) |=> !writeInProgress;
  endproperty
  a_hw_reject: assert property (p_hw_reject)
    else $error("status write accepted in hardware protection");

  property p_prot_reject;
    @(posedge core_clk) disable iff (!rstn)
    (arWrReq && prot && idle) |=> !writeInProgress;
  endproperty
  a_prot_reject: assert property (p_prot_reject)
    else $error("array write accepted into protected region");

  property p_nowel_reject;
    @(posedge core_clk) disable iff (!rstn)
    (ceRise && !writeEnableLatch && idle) |=> !writeInProgress;
  endproperty
  a_nowel_reject: assert property (p_nowel_reject)
    else $error("write started with latch clear");

  property p_cov_status;
    @(posedge core_clk) disable iff (!rstn)
    stAcc ##1 writeInProgress;
  endproperty
  c_cov_status: cover property (p_cov_status);

  property p_cov_array;
    @(posedge core_clk) disable iff (!rstn)
    arAcc ##1 writeInProgress;
  endproperty
  c_cov_array: cover property (p_cov_array);

  property p_cov_hpm;
    @(posedge core_clk) disable iff (!rstn)
    $rose(hardwareProtectedMode);
  endproperty
  c_cov_hpm: cover property (p_cov_hpm);

  property p_cov_done;
    @(posedge core_clk) disable iff (!rstn)
    $fell(writeInProgress);
  endproperty
  c_cov_done: cover property (p_cov_done);
endmodule : see_core

// >>> bench/see_host.sv
// Host model: mode 0 serial frames, clock still between frames
`timescale 1ns/1ps
module see_host (
  output logic spiClk,
  output logic chipEnableN,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic oeSeen;
  logic oeAfter;

  initial begin
    spiClk = 1'b0;
    chipEnableN = 1'b1;
    serialIn = 1'b1;
    oeSeen = 1'b0;
    oeAfter = 1'b0;
  end

  // One bit: data set while low, sampled just before the rise
  task automatic bitx(input logic d, output logic q);
    serialIn = d;
    #40;
    q = serialOut;
    oeSeen = oeSeen | serialOutOe;
    spiClk = 1'b1;
    #40;
    spiClk = 1'b0;
  endtask : bitx

  task automatic run(input int nRx, input int nExtra);
    logic [7:0] b;
    logic [7:0] r;
    logic q;
    oeSeen = 1'b0;
    rxq = {};
    chipEnableN = 1'b0;
    while (txq.size() > 0) begin
      b = txq.pop_front();
      for (int i = 7; i >= 0; i--) bitx(b[i], q);
    end
    for (int n = 0; n < nRx; n++) begin
      for (int i = 7; i >= 0; i--) begin
        bitx(~serialIn, q);
        r[i] = q;
      end
      rxq.push_back(r);
    end
    // Don't-care bits toggle so no stale level passes
    for (int n = 0; n < nExtra; n++) bitx(~serialIn, q);
    // deselect after last rise, before next
    #20;
    chipEnableN = 1'b1;
    #1;
    oeAfter = serialOutOe;
    serialIn = ~serialIn;
  endtask : run
endmodule : see_host

// >>> bench/tb.sv
// Self-checking bench for the serial EEPROM core
`timescale 1ns/1ps
module tb;
  import see_pkg::*;
  localparam int PG = 8;
  localparam int TW = 200;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic protectPinN = 1'b1;
  wire logic spiClk, chipEnableN, serialIn, serialOut, serialOutOe;
  logic [7:0] statusByte;
  logic writeInProgress, writeEnableLatch, statusWriteDisable;
  logic blockProtectHi, blockProtectLo;
  logic hardwareProtectedMode, softwareProtectedMode;
  int miscompares = 0;
  int nTests = 0;
  int seed = 71;
  logic [7:0] mem [MEM_WORDS];
  logic swd = 1'b0;
  logic nswd = 1'b0;
  logic [1:0] bp = 2'h0;
  logic [1:0] nbp = 2'h0;
  logic write_enable_latch = 1'b0;
  logic [10:0] pa[$];
  logic [7:0] pd[$];

  always #12.5 core_clk = ~core_clk;

  see_core #(.PAGE_BYTES(PG), .TW_CYCLES(TMR_W'(TW))) see_core_i (
    .core_clk(core_clk), .rstn(rstn), .spiClk(spiClk),
    .chipEnableN(chipEnableN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutOe(serialOutOe),
    .protectPinN(protectPinN), .statusByte(statusByte),
    .writeInProgress(writeInProgress),
    .writeEnableLatch(writeEnableLatch),
    .statusWriteDisable(statusWriteDisable),
    .blockProtectHi(blockProtectHi), .blockProtectLo(blockProtectLo),
    .hardwareProtectedMode(hardwareProtectedMode),
    .softwareProtectedMode(softwareProtectedMode));

  see_host see_host_i (.spiClk(spiClk), .chipEnableN(chipEnableN),
    .serialIn(serialIn), .serialOut(serialOut),
    .serialOutOe(serialOutOe));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  function automatic logic prot(input logic [10:0] x);
    return bp == 2'h3 || (bp == 2'h2 && x >= 11'h400) ||
      (bp == 2'h1 && x >= 11'h600);
  endfunction : prot

  task automatic statCheck();
    logic [7:0] s;
    logic [7:0] m;
    s = {3'h0, statusWriteDisable, blockProtectHi, blockProtectLo,
      writeEnableLatch, writeInProgress};
    m = {6'h0, hardwareProtectedMode, softwareProtectedMode};
    chk(statusByte, {swd, 3'h0, bp, write_enable_latch, 1'b0});
    chk(s, {3'h0, swd, bp, write_enable_latch, 1'b0});
    chk(m, {6'h0, swd & ~protectPinN, ~(swd & ~protectPinN)});
  endtask : statCheck

  task automatic settle(input logic acc);
    int k;
    repeat (8) @(negedge core_clk);
    chk({7'h0, writeInProgress}, {7'h0, acc});
    chk(statusByte, {swd, 3'h0, bp, write_enable_latch, acc});
    k = 0;
    while (writeInProgress !== 1'b0 && k < 4 * TW) begin
      @(negedge core_clk);
      k++;
    end
    chk({7'h0, k > TW / 4 && k < 4 * TW}, {7'h0, acc});
    if (acc) begin
      while (pa.size() > 0) mem[pa.pop_front()] = pd.pop_front();
      swd = nswd;
      bp = nbp;
      write_enable_latch = 1'b0;
    end
    pa = {};
    pd = {};
    @(negedge core_clk);
    statCheck();
  endtask : settle

  task automatic hdr(input logic [7:0] op, input logic [10:0] a);
    logic [31:0] r;
    r = $random(seed);
    see_host_i.txq.push_back(op);
    see_host_i.txq.push_back({r[4:0], a[10:8]});
    see_host_i.txq.push_back(a[7:0]);
  endtask : hdr

  task automatic write_enable_cmd();
    see_host_i.txq.push_back(OP_WR_ENABLE);
    see_host_i.run(0, 0);
    repeat (6) @(negedge core_clk);
    write_enable_latch = 1'b1;
  endtask : write_enable_cmd

  task automatic ws(input logic [7:0] d, input int extra);
    logic acc;
    acc = write_enable_latch && !(swd && !protectPinN) && extra == 0;
    nswd = d[SR_SWD];
    nbp = d[SR_BPHI:SR_BPLO];
    see_host_i.txq.push_back(OP_STATUS_WR);
    see_host_i.txq.push_back(d);
    see_host_i.run(0, extra);
    settle(acc);
  endtask : ws

  task automatic rd(input logic [10:0] a, input int n, input int extra,
    input logic ok);
    hdr(OP_ARRAY_RD, a);
    see_host_i.run(n, extra);
    chk({7'h0, see_host_i.oeSeen}, {7'h0, ok});
    chk({7'h0, see_host_i.oeAfter}, 8'h00);
    for (int i = 0; i < n && ok; i++)
      chk(see_host_i.rxq[i], mem[(int'(a) + i) % MEM_WORDS]);
    repeat (6) @(negedge core_clk);
  endtask : rd

  task automatic wr(input logic [10:0] a, input int n, input int extra,
    input logic busyRd);
    logic [31:0] r;
    logic [10:0] pb;
    logic acc;
    pb = a - 11'(a % PG);
    acc = write_enable_latch && extra == 0 && n > 0 && !prot(pb);
    nswd = swd;
    nbp = bp;
    hdr(OP_ARRAY_WR, a);
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      see_host_i.txq.push_back(r[7:0]);
      pa.push_back(pb + 11'((a % PG + i) % PG));
      pd.push_back(r[7:0]);
    end
    see_host_i.run(0, extra);
    if (busyRd) begin
      repeat (6) @(negedge core_clk);
      rd(a, 0, 0, 1'b0);
    end
    settle(acc);
  endtask : wr

  initial begin
    #2ms;
    miscompares++;
    test_done();
  end

  initial begin
    for (int i = 0; i < MEM_WORDS; i++) mem[i] = MEM_RESET;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    repeat (6) @(negedge core_clk);
    statCheck();
    write_enable_cmd();
    see_host_i.txq.push_back(OP_WR_DISABLE);
    see_host_i.run(0, 0);
    repeat (6) @(negedge core_clk);
    write_enable_latch = 1'b0;
    statCheck();
    ws(8'h8C, 0);
    $display("test reset and latch done");
    for (int b = 0; b < 4; b++) begin
      write_enable_cmd();
      ws({4'h7, 2'(b), 2'h3}, 0);
      for (int j = 0; j < 3; j++) begin
        write_enable_cmd();
        wr(11'h3F8 + 11'(j * 11'h200), 1, 0, 1'b0);
      end
    end
    write_enable_cmd();
    ws(8'h00, 0);
    $display("test protect regions done");
    write_enable_cmd();
    wr(11'h7FE, 5, 0, 1'b1);
    rd(11'h7FC, 6, 3, 1'b1);
    $display("test page wrap and read done");
    write_enable_cmd();
    wr(11'h100, 2, 3, 1'b0);
    ws(8'h80, 2);
    ws(8'h80, 0);
    $display("test boundary discard done");
    @(negedge core_clk);
    protectPinN = 1'b0;
    repeat (4) @(negedge core_clk);
    statCheck();
    write_enable_cmd();
    ws(8'h0C, 0);
    wr(11'h010, 2, 0, 1'b0);
    wr(11'h018, 1, 0, 1'b0);
    protectPinN = 1'b1;
    repeat (4) @(negedge core_clk);
    write_enable_cmd();
    ws(8'h84, 0);
    write_enable_cmd();
    ws(8'h00, 0);
    protectPinN = 1'b0;
    write_enable_cmd();
    ws(8'h88, 0);
    protectPinN = 1'b1;
    repeat (4) @(negedge core_clk);
    statCheck();
    rd(11'h3F8, 24, 0, 1'b1);
    $display("test pin modes done");
    test_done();
  end
endmodule : tb
